// file: caption_defs.svh
// Notes on behaviour
// - Revision bit in mode_control_3 is read only; writes leave it unchanged.
// - With vbi_pass_enable set, VBI lines pass; clear, they are blanked.
// - VBI insertion is off in slave timing mode 0, whatever vbi_pass_enable says.
// - Blank-input control beats vbi_pass_enable and suppresses VBI insertion.
// - Two-bit clock_out_select picks 27 MHz, 13.5 MHz or disabled clock output.
// - overlay_enable at 1 enables the OSD overlay; at 0 it stays off.
// - zero_input_colour 0 shows zero input as coded; 1 forces black.
// - Twelve OSD registers hold 4-bit Y, Cb, Cr, each padded with four zeros.
// - Captions go out on line 21 of odd fields and line 284 of even.
// - Each caption line opens with seven sine cycles locked to bit timing.
// - After run-in, blanking level for two bit periods, then a 1 start bit.
// - Sixteen bits follow: two bytes of seven data bits plus odd parity.
// - Odd field uses caption data registers; even field uses extended ones.
// - Run-in and caption timing are generated internally; host only loads data.
// - Pixel input is ignored during line 21 of odd fields and line 284 of even fields.
// - Caption data is single buffered and sent on the next caption line.
// - mode_control_3 sits at subaddress 12H.
// - Blank-input control decides if the external blank input counts in slave mode.
`ifndef CAPTION_DEFS_SVH
`define CAPTION_DEFS_SVH
`define IDX_CC_EXT_0    6'h08
`define IDX_CC_EXT_1    6'h09
`define IDX_CC_DATA_0   6'h0a
`define IDX_CC_DATA_1   6'h0b
`define IDX_MODE_3      6'h12
`define IDX_OSD_FIRST   6'h13
`define IDX_OSD_LAST    6'h1e
`define IDX_TIMING_CTL  6'h1f
`define IDX_STATUS      6'h20
`define MR3_REV_BIT     0
`define MR3_VBI_BIT     1
`define MR3_CLK_LSB     2
`define MR3_OSD_BIT     5
`define MR3_ZERO_BIT    6
`define TC_SLAVE_BIT    0
`define TC_MODE_LSB     1
`define TC_BLANK_BIT    3
`define CLK_CODE_27     2'h0
`define CLK_CODE_13     2'h1
`define LINE_CC_ODD     10'h015
`define LINE_CC_EVEN    10'h11c
`define LEVEL_BLANK     8'h10
`define LEVEL_BLACK     8'h10
`define LEVEL_CC_HIGH   8'h7e
`define LEVEL_SINE_MID  8'h47
`define CLK_MHZ         200
`define CC_BIT_NS       1986
`define CC_START_NS     10500
`define CC_STEP_CYC     ((`CC_BIT_NS * `CLK_MHZ) / (16 * 1000))
`define CC_START_CYC    ((`CC_START_NS * `CLK_MHZ) / 1000)
`define RUNIN_BITS      5'h07
`define GAP_BITS        5'h02
`define DATA_BITS       5'h11
`endif

// file: caption_pkg.sv
package caption_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_WAIT  = 5'h02,
    ST_RUNIN = 5'h04,
    ST_GAP   = 5'h08,
    ST_DATA  = 5'h10
  } cc_state_e;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
  } osd_colour_s;

  typedef struct packed {
    logic [1:0][7:0]   cc_data;
    logic [1:0][7:0]   cc_ext;
    logic              vbi_pass_enable;
    logic [1:0]        clock_out_select;
    logic              overlay_enable;
    logic              zero_input_colour;
    logic [11:0][11:0] osd;
    logic [3:0]        timing_ctl;
    logic              ack;
    logic [31:0]       rdata;
    logic [2:0]        blank_sync;
    logic              blank_stable;
    cc_state_e         state;
    logic [11:0]       cnt;
    logic [3:0]        phase;
    logic [4:0]        bit_cnt;
    logic [16:0]       shift;
    logic [7:0]        video;
    osd_colour_s       osd_out;
  } core_s;
endpackage

// file: caption_vbi_osd_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "caption_defs.svh"
module caption_vbi_osd_control
  import caption_pkg::*;
#(
  parameter logic REVISION = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [9:0]  line_num,
  input  wire logic        field_odd,
  input  wire logic        line_start,
  input  wire logic        vbi_line,
  input  wire logic [7:0]  pix_in,
  input  wire logic        blank_in_n,
  input  wire logic [3:0]  osd_index,
  output logic [7:0]       video_out,
  output osd_colour_s      osd_colour,
  output logic             overlay_on,
  output logic             clk_out_enable,
  output logic             clk_out_half
);
  // REVISION is an arbitrary neutral value.

  core_s r_r;
  core_s r_nxt;

  function automatic logic [7:0] cc_byte(input logic [7:0] d);
    cc_byte = {~^d[6:0], d[6:0]};
  endfunction

  function automatic logic [7:0] sine16(input logic [3:0] p);
    case (p)
      4'h0, 4'h8: sine16 = `LEVEL_SINE_MID;
      4'h1, 4'h7: sine16 = `LEVEL_SINE_MID + 8'h15;
      4'h2, 4'h6: sine16 = `LEVEL_SINE_MID + 8'h27;
      4'h3, 4'h5: sine16 = `LEVEL_SINE_MID + 8'h33;
      4'h4:       sine16 = `LEVEL_SINE_MID + 8'h37;
      4'h9, 4'hf: sine16 = `LEVEL_SINE_MID - 8'h15;
      4'ha, 4'he: sine16 = `LEVEL_SINE_MID - 8'h27;
      4'hb, 4'hd: sine16 = `LEVEL_SINE_MID - 8'h33;
      default:    sine16 = `LEVEL_SINE_MID - 8'h37;
    endcase
  endfunction

  logic [5:0] idx;
  logic       wr_take;
  logic       cc_now;
  logic       slave_mode0;
  logic       honour_blank;
  logic       vbi_effective;
  logic       step_end;
  logic       bit_end;
  logic [7:0] cc_level;
  logic [3:0] osd_slot;

  assign idx         = address[7:2];
  assign wr_take     = write && r_r.ack && byteenable[0];
  assign waitrequest = (read || write) && !r_r.ack;
  assign readdata    = r_r.rdata;
  assign video_out   = r_r.video;
  assign osd_colour  = r_r.osd_out;
  assign overlay_on  = r_r.overlay_enable;
  assign osd_slot    = 4'(idx - `IDX_OSD_FIRST);

  // Codes 00 and 01 run the clock; 1x turns it off.
  assign clk_out_enable = !r_r.clock_out_select[1];
  assign clk_out_half   = r_r.clock_out_select == `CLK_CODE_13;

  assign cc_now = (field_odd && line_num == `LINE_CC_ODD) ||
                  (!field_odd && line_num == `LINE_CC_EVEN);
  assign slave_mode0 = r_r.timing_ctl[`TC_SLAVE_BIT] &&
                       r_r.timing_ctl[`TC_MODE_LSB +: 2] == 2'h0;
  assign honour_blank = r_r.timing_ctl[`TC_SLAVE_BIT] &&
                        r_r.timing_ctl[`TC_BLANK_BIT] && !r_r.blank_stable;
  assign vbi_effective = r_r.vbi_pass_enable && !slave_mode0 &&
                         !r_r.timing_ctl[`TC_BLANK_BIT];
  assign step_end = r_r.cnt == 12'(`CC_STEP_CYC - 1);
  assign bit_end  = step_end && r_r.phase == 4'hf;

  always_comb begin
    case (r_r.state)
      ST_RUNIN: cc_level = sine16(r_r.phase);
      ST_DATA:  cc_level = r_r.shift[0] ? `LEVEL_CC_HIGH : `LEVEL_BLANK;
      default:  cc_level = `LEVEL_BLANK;
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.ack = (read || write) && !r_r.ack;
    if (read && !r_r.ack) begin
      r_nxt.rdata = 32'h0;
      case (idx)
        `IDX_CC_EXT_0:   r_nxt.rdata[7:0] = r_r.cc_ext[0];
        `IDX_CC_EXT_1:   r_nxt.rdata[7:0] = r_r.cc_ext[1];
        `IDX_CC_DATA_0:  r_nxt.rdata[7:0] = r_r.cc_data[0];
        `IDX_CC_DATA_1:  r_nxt.rdata[7:0] = r_r.cc_data[1];
        `IDX_MODE_3:     r_nxt.rdata[7:0] = {1'b0, r_r.zero_input_colour,
                                             r_r.overlay_enable, 1'b0,
                                             r_r.clock_out_select,
                                             r_r.vbi_pass_enable, REVISION};
        `IDX_TIMING_CTL: r_nxt.rdata[3:0] = r_r.timing_ctl;
        `IDX_STATUS:     r_nxt.rdata[7:0] = {2'h0, cc_now, r_r.blank_stable,
                                             r_r.state != ST_IDLE, r_r.bit_cnt[2:0]};
        default: begin
          if (idx >= `IDX_OSD_FIRST && idx <= `IDX_OSD_LAST) begin
            r_nxt.rdata[11:0] = r_r.osd[osd_slot];
          end
        end
      endcase
    end
    if (wr_take) begin
      case (idx)
        `IDX_CC_EXT_0:  r_nxt.cc_ext[0] = writedata[7:0];
        `IDX_CC_EXT_1:  r_nxt.cc_ext[1] = writedata[7:0];
        `IDX_CC_DATA_0: r_nxt.cc_data[0] = writedata[7:0];
        `IDX_CC_DATA_1: r_nxt.cc_data[1] = writedata[7:0];
        `IDX_MODE_3: begin
          // The revision bit and the reserved top bit have no storage.
          r_nxt.vbi_pass_enable   = writedata[`MR3_VBI_BIT];
          r_nxt.clock_out_select  = writedata[`MR3_CLK_LSB +: 2];
          r_nxt.overlay_enable    = writedata[`MR3_OSD_BIT];
          r_nxt.zero_input_colour = writedata[`MR3_ZERO_BIT];
        end
        `IDX_TIMING_CTL: r_nxt.timing_ctl = writedata[3:0];
        default: begin
          if (idx >= `IDX_OSD_FIRST && idx <= `IDX_OSD_LAST && byteenable[1]) begin
            r_nxt.osd[osd_slot] = writedata[11:0];
          end
        end
      endcase
    end

    r_nxt.blank_sync = {r_r.blank_sync[1:0], blank_in_n};
    if (r_r.blank_sync[1] == r_r.blank_sync[2]) begin
      r_nxt.blank_stable = r_r.blank_sync[2];
    end

    // The line sequencer runs without host help once a caption line starts.
    case (r_r.state)
      ST_IDLE: begin
        if (line_start && cc_now) begin
          // Bytes are taken straight from the registers at line start, so a
          // late write misses this line rather than tearing it.
          if (field_odd) begin
            r_nxt.shift = {cc_byte(r_r.cc_data[1]), cc_byte(r_r.cc_data[0]), 1'b1};
          end else begin
            r_nxt.shift = {cc_byte(r_r.cc_ext[1]), cc_byte(r_r.cc_ext[0]), 1'b1};
          end
          r_nxt.cnt   = 12'h0;
          r_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (r_r.cnt == 12'(`CC_START_CYC - 1)) begin
          r_nxt.cnt     = 12'h0;
          r_nxt.phase   = 4'h0;
          r_nxt.bit_cnt = 5'h0;
          r_nxt.state   = ST_RUNIN;
        end else begin
          r_nxt.cnt = r_r.cnt + 12'h1;
        end
      end
      ST_RUNIN, ST_GAP, ST_DATA: begin
        r_nxt.cnt = step_end ? 12'h0 : r_r.cnt + 12'h1;
        if (step_end) begin
          r_nxt.phase = r_r.phase + 4'h1;
        end
        if (bit_end) begin
          r_nxt.bit_cnt = r_r.bit_cnt + 5'h1;
          if (r_r.state == ST_RUNIN && r_r.bit_cnt == `RUNIN_BITS - 5'h1) begin
            r_nxt.bit_cnt = 5'h0;
            r_nxt.state   = ST_GAP;
          end else if (r_r.state == ST_GAP && r_r.bit_cnt == `GAP_BITS - 5'h1) begin
            r_nxt.bit_cnt = 5'h0;
            r_nxt.state   = ST_DATA;
          end else if (r_r.state == ST_DATA) begin
            r_nxt.shift = {1'b0, r_r.shift[16:1]};
            if (r_r.bit_cnt == `DATA_BITS - 5'h1) begin
              r_nxt.state = ST_IDLE;
            end
          end
        end
      end
      default: r_nxt.state = ST_IDLE;
    endcase

    if (cc_now) begin
      r_nxt.video = cc_level;
    end else if (honour_blank) begin
      r_nxt.video = `LEVEL_BLANK;
    end else if (vbi_line && !vbi_effective) begin
      r_nxt.video = `LEVEL_BLANK;
    end else if (r_r.zero_input_colour && pix_in == 8'h00) begin
      r_nxt.video = `LEVEL_BLACK;
    end else begin
      r_nxt.video = pix_in;
    end

    r_nxt.osd_out = '{y:  {r_r.osd[osd_index][11:8], 4'h0},
                      cb: {r_r.osd[osd_index][7:4], 4'h0},
                      cr: {r_r.osd[osd_index][3:0], 4'h0}};
    if (osd_index > 4'hb) begin
      r_nxt.osd_out = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_r              <= '0;
      r_r.state        <= ST_IDLE;
      r_r.blank_sync   <= 3'h7;
      r_r.blank_stable <= 1'b1;
      r_r.video        <= `LEVEL_BLANK;
    end else begin
      r_r <= r_nxt;
    end
  end

  default clocking cb_main @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_REV_RO: assert property (
    read && r_r.ack && idx == `IDX_MODE_3 |=> readdata[`MR3_REV_BIT] == REVISION
  ) else $error("revision bit read back wrong");
  AST_VBI_BLANK: assert property (
    vbi_line && !cc_now && !honour_blank && !r_r.vbi_pass_enable
      |=> video_out == `LEVEL_BLANK
  ) else $error("VBI line not blanked");
  AST_SLAVE0: assert property (
    vbi_line && !cc_now && slave_mode0 |=> video_out == `LEVEL_BLANK
  ) else $error("VBI passed in slave mode 0");
  AST_BLANK_PRI: assert property (
    vbi_line && !cc_now && r_r.timing_ctl[`TC_BLANK_BIT] |=> video_out == `LEVEL_BLANK
  ) else $error("blank input control lost priority");
  AST_CLK_SEL: assert property (
    wr_take && idx == `IDX_MODE_3 && writedata[`MR3_CLK_LSB +: 2] == `CLK_CODE_27
      |=> clk_out_enable && !clk_out_half
  ) else $error("27 MHz code not applied");
  AST_OSD_EN: assert property (
    wr_take && idx == `IDX_MODE_3 |=> overlay_on == $past(writedata[`MR3_OSD_BIT])
  ) else $error("overlay enable not written");
  AST_BLACK: assert property (
    !cc_now && !honour_blank && !vbi_line && r_r.zero_input_colour && pix_in == 8'h00
      |=> video_out == `LEVEL_BLACK
  ) else $error("zero input not forced black");
  AST_OSD_PAD: assert property (
    osd_colour.y[3:0] == 4'h0 && osd_colour.cb[3:0] == 4'h0 && osd_colour.cr[3:0] == 4'h0
  ) else $error("OSD low nibble not zero");
  AST_RUNIN_GAP: assert property (
    r_r.state == ST_RUNIN && bit_end && r_r.bit_cnt == 5'h6 |=> r_r.state == ST_GAP
  ) else $error("run-in length wrong");
  AST_GAP_LEVEL: assert property (
    r_r.state == ST_GAP && cc_now |=> video_out == `LEVEL_BLANK
  ) else $error("gap not at blanking level");
  AST_START_BIT: assert property (
    $rose(r_r.state == ST_DATA) |-> r_r.shift[0]
  ) else $error("start bit not one");
  AST_CC_IGNORE: assert property (
    cc_now && r_r.state == ST_IDLE |=> video_out == `LEVEL_BLANK
  ) else $error("pixel data leaked into caption line");
  AST_BUS_ANSWER: assert property (
    (read || write) |-> ##[0:1] !waitrequest
  ) else $error("bus answer late");

  COV_ODD_LINE: cover property (
    r_r.state == ST_DATA && bit_end && r_r.bit_cnt == 5'h10 && field_odd);
  COV_EVEN_LINE: cover property (
    r_r.state == ST_DATA && bit_end && r_r.bit_cnt == 5'h10 && !field_odd);
  COV_RUNIN: cover property ($rose(r_r.state == ST_RUNIN));
  COV_MR3_WRITE: cover property (wr_take && idx == `IDX_MODE_3);
endmodule
`default_nettype wire

// file: tv_model.sv
`timescale 1ns/1ps
`default_nettype none
module tv_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  video,
  input  wire logic [9:0]  line_num,
  input  wire logic        field_odd,
  input  wire logic        line_start,
  output logic [16:0]      bits,
  output logic [3:0]       crossings,
  output logic             gap_ok,
  output logic [7:0]       frames
);
  logic [7:0] prev;
  // The receiver slices each bit at its centre, so a one-cycle skew in the sender is harmless.
  initial begin
    bits = 17'h0;
    crossings = 4'h0;
    gap_ok = 1'b0;
    frames = 8'h0;
    prev = 8'h0;
    forever begin
      @(posedge clk_sys);
      if (line_start && ((field_odd && line_num == 10'd21) ||
          (!field_odd && line_num == 10'd284))) begin
        crossings = 4'h0;
        repeat (2101) @(posedge clk_sys);
        prev = video;
        for (int i = 0; i < 2688; i++) begin
          @(posedge clk_sys);
          if (prev <= 8'h47 && video > 8'h47) begin
            crossings = crossings + 4'h1;
          end
          prev = video;
        end
        repeat (191) @(posedge clk_sys);
        gap_ok = (video === 8'h10);
        repeat (384) @(posedge clk_sys);
        gap_ok = gap_ok && (video === 8'h10);
        for (int k = 0; k < 17; k++) begin
          repeat (384) @(posedge clk_sys);
          bits[k] = (video > 8'h47);
        end
        frames = frames + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "caption_defs.svh"
module tb_top
  import caption_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset, read, write, field_odd, line_start, vbi_line, blank_in_n;
  logic [7:0]  address, pix_in, video_out, frames;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable, osd_index, crossings;
  logic [9:0]  line_num;
  logic [16:0] bits;
  logic        waitrequest, overlay_on, clk_out_enable, clk_out_half, gap_ok;
  logic [11:0] v;
  osd_colour_s osd_colour;
  int          fail_count = 0;
  int          tests_run = 0;

  always #2.5 clk_sys = ~clk_sys;

  caption_vbi_osd_control u_dut (.clk_sys(clk_sys), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .line_num(line_num),
    .field_odd(field_odd), .line_start(line_start), .vbi_line(vbi_line), .pix_in(pix_in),
    .blank_in_n(blank_in_n), .osd_index(osd_index), .video_out(video_out),
    .osd_colour(osd_colour), .overlay_on(overlay_on), .clk_out_enable(clk_out_enable),
    .clk_out_half(clk_out_half));

  tv_model u_tv (.clk_sys(clk_sys), .video(video_out), .line_num(line_num),
    .field_odd(field_odd), .line_start(line_start), .bits(bits), .crossings(crossings),
    .gap_ok(gap_ok), .frames(frames));

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data is taken at the rising edge at which waitrequest is seen low, and the
  // request is dropped only after that edge.
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    logic done;
    int   n;
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= wd;
    done = 1'b0;
    n = 0;
    while (!done && n < 20) begin
      @(posedge clk_sys);
      done = (waitrequest === 1'b0);
      rd = readdata;
      n++;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (!done) begin
      fail_count++;
      $display("wrong value at %0t: no bus answer", $time);
      stop_test();
    end
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  task automatic vchk(input logic [7:0] exp);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check({24'h0, video_out}, {24'h0, exp});
    @(posedge clk_sys);
  endtask

  function automatic logic [16:0] cc_bits(input logic [7:0] b0, input logic [7:0] b1);
    return {~^b1[6:0], b1[6:0], ~^b0[6:0], b0[6:0], 1'b1};
  endfunction

  task automatic cap_line(input logic odd, input logic [9:0] ln, input logic [16:0] exp);
    logic [7:0] f0;
    int         n;
    f0 = frames;
    field_odd <= odd;
    line_num <= ln;
    line_start <= 1'b1;
    pix_in <= 8'hff;
    @(posedge clk_sys);
    line_start <= 1'b0;
    repeat (1000) @(posedge clk_sys);
    check({24'h0, video_out}, {24'h0, `LEVEL_BLANK});
    n = 0;
    while (frames === f0 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (frames === f0) begin
      fail_count++;
      $display("wrong value at %0t: no caption frame seen", $time);
      stop_test();
    end
    check({15'h0, bits}, {15'h0, exp});
    check({31'h0, crossings >= 4'd6 && crossings <= 4'd8}, 32'h1);
    check({31'h0, gap_ok}, 32'h1);
    line_num <= ln - 10'd1;
    // The sequencer is still sending the last bit; a new line start would be refused.
    repeat (400) @(posedge clk_sys);
  endtask

  initial begin
    reset = 1'b1;
    {read, write, line_start, vbi_line, field_odd} = 5'h0;
    address = 8'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    line_num = 10'd20;
    pix_in = 8'h00;
    blank_in_n = 1'b1;
    osd_index = 4'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rdc(`IDX_MODE_3, 32'h0);
    check({29'h0, overlay_on, clk_out_enable, clk_out_half}, 32'h2);
    rdc(6'h3f, 32'h0);
    rdc(`IDX_STATUS, 32'h10);
    bus(1'b1, `IDX_MODE_3, 32'h7f);
    rdc(`IDX_MODE_3, 32'h6e);
    check({31'h0, overlay_on}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `IDX_MODE_3, c << 2);
      @(negedge clk_sys);
      check({30'h0, clk_out_enable, clk_out_half}, c == 0 ? 2 : c == 1 ? 3 : 0);
    end
    check({31'h0, overlay_on}, 32'h0);
    for (int i = 0; i < 13; i++) begin
      v = {i[3:0], ~i[3:0], i[3:0] + 4'h3};
      if (i < 12) begin
        bus(1'b1, `IDX_OSD_FIRST + i[5:0], {20'h0, v});
        rdc(`IDX_OSD_FIRST + i[5:0], {20'h0, v});
      end
      osd_index <= i[3:0];
      repeat (3) @(posedge clk_sys);
      check({8'h0, osd_colour}, i < 12 ? {8'h0, v[11:8], 4'h0, v[7:4], 4'h0, v[3:0], 4'h0}
        : 32'h0);
    end
    vchk(8'h00);
    bus(1'b1, `IDX_MODE_3, 32'h40);
    vchk(8'h10);
    pix_in <= 8'h55;
    vbi_line <= 1'b1;
    vchk(8'h10);
    bus(1'b1, `IDX_MODE_3, 32'h02);
    vchk(8'h55);
    bus(1'b1, `IDX_TIMING_CTL, 32'h1);
    vchk(8'h10);
    bus(1'b1, `IDX_TIMING_CTL, 32'h3);
    rdc(`IDX_TIMING_CTL, 32'h3);
    vchk(8'h55);
    bus(1'b1, `IDX_TIMING_CTL, 32'hb);
    vchk(8'h10);
    vbi_line <= 1'b0;
    blank_in_n <= 1'b0;
    vchk(8'h10);
    rdc(`IDX_STATUS, 32'h0);
    bus(1'b1, `IDX_TIMING_CTL, 32'h3);
    vchk(8'h55);
    blank_in_n <= 1'b1;
    // Bytes go in as pairs while the timing generator is still on the line before.
    bus(1'b1, `IDX_CC_DATA_0, 32'hc1);
    bus(1'b1, `IDX_CC_DATA_1, 32'h14);
    bus(1'b1, `IDX_CC_EXT_0, 32'h7f);
    bus(1'b1, `IDX_CC_EXT_1, 32'h80);
    cap_line(1'b1, 10'd21, cc_bits(8'hc1, 8'h14));
    cap_line(1'b0, 10'd284, cc_bits(8'h7f, 8'h80));
    bus(1'b1, `IDX_CC_DATA_0, 32'h0);
    bus(1'b1, `IDX_CC_DATA_1, 32'h0);
    cap_line(1'b1, 10'd21, cc_bits(8'h00, 8'h00));
    stop_test();
  end
endmodule
`default_nettype wire
